// ---- dv/sac_mod_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// modulator stand-in: one tick every TICK_DIV clocks, raw word held
module sac_mod_model #(parameter int TICK_DIV = 2) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // sample chosen by the bench
  input wire logic [23:0] raw_value,
  // modulator outputs
  output logic mod_tick,
  output logic [23:0] raw_result
);
  int div_ff; // tick divider
  // ticks run freely; the raw word follows raw_value at once, whenever the bench changes it
  always_ff @(posedge clock) begin
    if (sys_rst || div_ff == TICK_DIV - 1) begin
      div_ff <= 0;
    end else begin
      div_ff <= div_ff + 1;
    end
    mod_tick <= !sys_rst && div_ff == TICK_DIV - 1;
  end
  assign raw_result = raw_value;
endmodule : sac_mod_model
`default_nettype wire

// ---- dv/tb_shunt_adc_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_shunt_adc_config_regs
  import sac_pkg::*;
;
  logic clock = 0, sys_rst = 1, reg_wr_en = 0, standby = 0, start_single = 0;
  logic [7:0] reg_addr = 8'h00, ra;
  logic [15:0] reg_wr_data = 16'h0000, reg_rd_data;
  logic [23:0] raw_value = 24'h000000, raw_result, conversion_result, raw, off;
  logic reg_hit, mod_tick, input_swap, input_short, input_test_dac, chop_active, data_ready;
  logic current_source_steer, current_sink_steer;
  logic [1:0] analog_gain, current_source_level, current_sink_level, conversion_counter, cnt;
  int miscompares = 0, cmp_count = 0, cycles = 0, n, seed = 32'h26ed171f;
  sac_mod_model #(.TICK_DIV(2)) modulator (.clock, .sys_rst, .raw_value, .mod_tick, .raw_result);
  sac_config_regs DUT (.clock, .sys_rst, .reg_wr_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_hit,
    .mod_tick, .standby, .start_single, .raw_result, .analog_gain, .input_swap, .input_short,
    .input_test_dac, .current_source_steer, .current_sink_steer, .current_source_level,
    .current_sink_level, .chop_active, .conversion_result, .conversion_counter, .data_ready);
  initial begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one write strobe, then released for a cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask : wr
  // read data is combinational, so look just after the address settles
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    #1 chk($sformatf("reg_%h", a), exp, reg_rd_data);
  endtask : rdchk
  task automatic wait_rdy(output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (data_ready !== 1'b1 && k < 3000);
  endtask : wait_rdy
  task automatic count_rdy(input int len, output int k);
    k = 0;
    repeat (len) begin
      @(posedge clock);
      if (data_ready === 1'b1) k++;
    end
  endtask : count_rdy
  function automatic logic [15:0] mask(input logic [7:0] a);
    case (a)
      ADDR_CONV_CONFIG: return MASK_CONV_CONFIG;
      ADDR_GAIN_CONFIG: return MASK_GAIN_CONFIG;
      ADDR_OCAL_UPPER: return MASK_OCAL_UPPER;
      default: return MASK_OCAL_LOWER;
    endcase
  endfunction : mask
  // offset removed first, then the digital part of gains 16 and 32
  function automatic logic [23:0] exp_res(input logic [23:0] r, o, input logic [1:0] g);
    return (r - o) << (g == 2'h3 ? 2 : g == 2'h2 ? 1 : 0);
  endfunction : exp_res
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(8'h82, 16'h0400);
    rdchk(8'h83, 16'h8010);
    rdchk(8'h84, 16'h0000);
    rdchk(8'h85, 16'h0000);
    // unmapped place: write ignored, reads zero, no hit
    wr(8'h86, 16'hffff);
    rdchk(8'h86, 16'h0000);
    chk("reg_hit", 24'h0, reg_hit);
    wr(8'h85, 16'hffff);
    rdchk(8'h85, 16'hff00);
    wr(8'h84, 16'hffff);
    rdchk(8'h84, 16'hffff);
    wr(8'h82, 16'hffff);
    rdchk(8'h82, 16'h0f0f);
    for (int i = 0; i < 12; i++) begin
      // the address is picked in a bench variable so the bus only moves inside the tasks
      ra = 8'h82 + 8'($unsigned($random(seed)) % 4);
      raw = $random(seed);
      wr(ra, raw[15:0]);
      rdchk(ra, raw[15:0] & mask(ra));
    end
    // every gain, mux, steer and level code reaches the front end
    for (int i = 0; i < 4; i++) begin
      wr(8'h83, 16'h8000 | 16'(i << 10) | 16'(i << 8) | 16'(i << 2) | 16'(3 - i) | 16'(i << 4));
      // the write lands on this very edge, so let the register settle first
      #1;
      chk("analog_gain", (i > 1) ? 24'h1 : 24'(i), analog_gain);
      chk("mux", 24'((i == 1) | (i == 2) << 1 | (i == 3) << 2), {input_test_dac, input_short, input_swap});
      chk("steer", 24'(i & 3), {current_source_steer, current_sink_steer});
      chk("levels", 24'(i << 2 | (3 - i)), {current_source_level, current_sink_level});
    end
    // continuous words at ratio 64: offset, gain scaling and pacing
    wr(8'h82, 16'h0000);
    for (int g = 0; g < 4; g++) begin
      raw = $random(seed);
      off = $random(seed);
      if (g == 0) begin
        raw = 24'h000000;
        off = 24'h000001;
      end
      @(posedge clock);
      raw_value <= raw;
      wr(8'h84, off[23:8]);
      wr(8'h85, {off[7:0], 8'h00});
      wr(8'h83, 16'h8000 | 16'(g << 10));
      wait_rdy(n);
      wait_rdy(n);
      cnt = conversion_counter;
      wait_rdy(n);
      chk("result", exp_res(raw, off, 2'(g)), conversion_result);
      chk("counter", 24'(2'(cnt + 2'h1)), conversion_counter);
      chk("period", 24'd128, 24'(n));
    end
    // chop wait adds its delay; ratio code 1 doubles the word time
    wr(8'h82, 16'h0009);
    #1;
    chk("chop_active", 24'h1, chop_active);
    wait_rdy(n);
    wait_rdy(n);
    chk("chop_period", 24'd136, 24'(n));
    wr(8'h82, 16'h0100);
    wait_rdy(n);
    wait_rdy(n);
    chk("osr_period", 24'd256, 24'(n));
    // disable, then standby, must zero result and counter
    wr(8'h83, 16'h0000);
    repeat (2) @(posedge clock);
    chk("off_result", 24'h0, {conversion_result[23:2], conversion_result[1:0] | conversion_counter});
    wr(8'h83, 16'h8000);
    wait_rdy(n);
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    chk("standby_result", 24'h0, {conversion_result[23:2], conversion_result[1:0] | conversion_counter});
    standby <= 1'b0;
    // single shot: nothing until armed, then exactly one word
    wr(8'h83, 16'h0000);
    wr(8'h82, 16'h0800);
    wr(8'h83, 16'h8000);
    count_rdy(400, n);
    chk("idle_words", 24'h0, 24'(n));
    start_single <= 1'b1;
    @(posedge clock);
    start_single <= 1'b0;
    count_rdy(400, n);
    chk("single_words", 24'h1, 24'(n));
    give_verdict();
  end
endmodule : tb_shunt_adc_config_regs
`default_nettype wire

// ---- src/sac_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// decoded configuration handed from the register file to the conversion core
interface sac_cfg_if;
  logic conv_mode_select;
  logic [2:0] oversampling_ratio;
  logic global_chop_enable;
  logic [2:0] global_chop_delay;
  logic channel_enable;
  logic [1:0] gain_select;
  logic [23:0] offset_calibration;
  modport regs (output conv_mode_select, oversampling_ratio, global_chop_enable, global_chop_delay,
                output channel_enable, gain_select, offset_calibration);
  modport core (input conv_mode_select, oversampling_ratio, global_chop_enable, global_chop_delay,
                input channel_enable, gain_select, offset_calibration);
endinterface : sac_cfg_if
`default_nettype wire

// ---- src/sac_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE_01] mode bit: 0 continuous, 1 single-shot
// [RULE_02] ratio code maps 64 to 8192, reset 100b
// [RULE_03] words come at modulator rate over ratio
// [RULE_04] bit 3 enables global chop, reset off
// [RULE_05] chop delay code selects 2 to 256 periods
// [RULE_06] disable or standby zeroes result and counter
// [RULE_07] gain code selects 4, 8, 16, 32
// [RULE_08] gains 16, 32 use analog 8 plus shift
// [RULE_09] mux: normal, swapped, grounded short, test DAC
// [RULE_10] source steer: 0 positive, 1 negative input
// [RULE_11] sink steer: resets to negative input
// [RULE_12] source level: off, 4, 40, 240 uA
// [RULE_13] sink level: off, 4, 40, 240 uA
// [RULE_14] 84h holds calibration bits 23:8
// [RULE_15] 85h high byte holds bits 7:0
// [RULE_16] reserved bits always read zero
// [RULE_17] calibration subtracted from each raw result
module sac_config_regs
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register access from the serial host interface
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  output logic reg_hit,
  // modulator side
  input wire logic mod_tick,
  input wire logic standby,
  input wire logic start_single,
  input wire logic [23:0] raw_result,
  // analog front end controls
  output logic [1:0] analog_gain,
  output logic input_swap,
  output logic input_short,
  output logic input_test_dac,
  output logic current_source_steer,
  output logic current_sink_steer,
  output logic [1:0] current_source_level,
  output logic [1:0] current_sink_level,
  output logic chop_active,
  // conversion results
  output logic [23:0] conversion_result,
  output logic [1:0] conversion_counter,
  output logic data_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // storage, masked so reserved bits never hold a one
  logic [15:0] conv_cfg_ff;
  logic [15:0] gain_cfg_ff;
  logic [15:0] ocal_up_ff;
  logic [15:0] ocal_lo_ff;

  // address decode
  wire sel_conv = reg_addr == ADDR_CONV_CONFIG;
  wire sel_gain = reg_addr == ADDR_GAIN_CONFIG;
  wire sel_up = reg_addr == ADDR_OCAL_UPPER;
  wire sel_lo = reg_addr == ADDR_OCAL_LOWER;

  // register writes; reserved bits dropped by the masks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      conv_cfg_ff <= RST_CONV_CONFIG; // RULE_01 RULE_02 RULE_04
      gain_cfg_ff <= RST_GAIN_CONFIG; // RULE_06 RULE_07 RULE_10 RULE_11 RULE_12 RULE_13
      ocal_up_ff <= RST_OCAL_UPPER; // RULE_14
      ocal_lo_ff <= RST_OCAL_LOWER; // RULE_15
    end else if (reg_wr_en) begin
      if (sel_conv) conv_cfg_ff <= reg_wr_data & MASK_CONV_CONFIG; // RULE_16
      if (sel_gain) gain_cfg_ff <= reg_wr_data & MASK_GAIN_CONFIG; // RULE_16
      if (sel_up) ocal_up_ff <= reg_wr_data & MASK_OCAL_UPPER; // RULE_14
      if (sel_lo) ocal_lo_ff <= reg_wr_data & MASK_OCAL_LOWER; // RULE_15
    end
  end

  // read mux; unmapped addresses read zero and drop reg_hit
  assign reg_hit = sel_conv | sel_gain | sel_up | sel_lo;
  assign reg_rd_data = sel_conv ? conv_cfg_ff :
                       sel_gain ? gain_cfg_ff :
                       sel_up ? ocal_up_ff :
                       sel_lo ? ocal_lo_ff : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // field decode towards the core
  sac_cfg_if cfg ();
  assign cfg.conv_mode_select = conv_cfg_ff[POS_CONV_MODE]; // RULE_01
  assign cfg.oversampling_ratio = conv_cfg_ff[POS_OSR +: 3]; // RULE_02
  assign cfg.global_chop_enable = conv_cfg_ff[POS_GC_EN]; // RULE_04
  assign cfg.global_chop_delay = conv_cfg_ff[POS_GC_DELAY +: 3]; // RULE_05
  assign cfg.channel_enable = gain_cfg_ff[POS_CH_EN]; // RULE_06
  assign cfg.gain_select = gain_cfg_ff[POS_GAIN +: 2]; // RULE_07
  assign cfg.offset_calibration = {ocal_up_ff, ocal_lo_ff[POS_OCAL_LOW +: 8]}; // RULE_14 RULE_15

  // front end controls; gains above 8 stay at analog 8
  wire [1:0] gain_code = cfg.gain_select;
  wire [1:0] mux_code = gain_cfg_ff[POS_MUX +: 2];
  assign analog_gain = gain_code[1] ? GAIN_CODE_X8 : gain_code; // RULE_07 RULE_08
  assign input_swap = mux_code == MUX_SWAPPED; // RULE_09
  assign input_short = mux_code == MUX_SHORT; // RULE_09
  assign input_test_dac = mux_code == MUX_TEST_DAC; // RULE_09
  assign current_source_steer = gain_cfg_ff[POS_SRC_STEER]; // RULE_10
  assign current_sink_steer = gain_cfg_ff[POS_SINK_STEER]; // RULE_11
  assign current_source_level = gain_cfg_ff[POS_SRC_LEVEL +: 2]; // RULE_12
  assign current_sink_level = gain_cfg_ff[POS_SINK_LEVEL +: 2]; // RULE_13
  assign chop_active = cfg.global_chop_enable & cfg.channel_enable; // RULE_04

  ////////////////////////////////////////////////////////////////////////////
  // conversion core
  sac_conv_core u_core (
    .clock(clock),
    .sys_rst(sys_rst),
    .cfg(cfg.core),
    .mod_tick(mod_tick),
    .standby(standby),
    .start_single(start_single),
    .raw_result(raw_result),
    .conversion_result(conversion_result),
    .conversion_counter(conversion_counter),
    .data_ready(data_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (sel_conv |-> (reg_rd_data & ~MASK_CONV_CONFIG) == 16'h0) and
    (sel_lo |-> reg_rd_data[7:0] == 8'h0)) // RULE_16
    else $error("reserved bits read nonzero");
  a_upper_write: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_wr_en && sel_up) |=> cfg.offset_calibration[23:8] == $past(reg_wr_data)) // RULE_14
    else $error("upper calibration not stored");
  a_lower_write: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_wr_en && sel_lo) |=> cfg.offset_calibration[7:0] == $past(reg_wr_data[15:8])) // RULE_15
    else $error("lower calibration not stored");
  a_gain_analog: assert property (@(posedge clock) disable iff (sys_rst)
    gain_code[1] |-> analog_gain == 2'h1) // RULE_08
    else $error("digital gain without analog 8");
  a_mux_onehot: assert property (@(posedge clock) disable iff (sys_rst)
    $onehot0({input_swap, input_short, input_test_dac})) // RULE_09
    else $error("input mux selection not exclusive");
  a_reset_values: assert property (@(posedge clock)
    $past(sys_rst) |-> (current_sink_steer && !current_source_steer && cfg.oversampling_ratio == 3'h4)) // RULE_11
    else $error("reset values wrong");

endmodule : sac_config_regs
`default_nettype wire

// ---- src/sac_conv_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// conversion pacing, chop settling, offset correction and digital gain
module sac_conv_core
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration
  sac_cfg_if.core cfg,
  // modulator side
  input wire logic mod_tick,
  input wire logic standby,
  input wire logic start_single,
  input wire logic [23:0] raw_result,
  // results
  output logic [23:0] conversion_result,
  output logic [1:0] conversion_counter,
  output logic data_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [13:0] dec_cnt_ff; // modulator periods within one output word
  logic [8:0] chop_cnt_ff; // remaining chop settling periods
  logic single_armed_ff; // single-shot request pending
  logic [23:0] result_ff;
  logic [1:0] count_ff;
  logic ready_ff;

  // enable gate: disabled or standby kills everything
  wire run = cfg.channel_enable & ~standby;
  // output word period, 64 shifted by the ratio code
  wire [13:0] word_len = 14'(14'h1 << (OSR_BASE_LOG2 + 32'(cfg.oversampling_ratio))); // RULE_02
  // chop wait, 2 shifted by the delay code
  wire [8:0] chop_len = 9'(9'h1 << (GC_DELAY_BASE_LOG2 + 32'(cfg.global_chop_delay))); // RULE_05
  wire single = cfg.conv_mode_select == CONV_SINGLE_SHOT; // RULE_01
  wire converting = run & (~single | single_armed_ff);
  wire word_done = converting & mod_tick & (chop_cnt_ff == 9'h0) & (dec_cnt_ff == word_len - 14'h1); // RULE_03
  // offset removal with sign, then digital gain on the top two codes
  wire [23:0] corrected = raw_result - cfg.offset_calibration; // RULE_17
  wire [23:0] scaled = (cfg.gain_select == 2'h3) ? {corrected[21:0], 2'h0} :
                       (cfg.gain_select == 2'h2) ? {corrected[22:0], 1'h0} : corrected; // RULE_08

  ////////////////////////////////////////////////////////////////////////////
  // decimation and chop settling counters
  always_ff @(posedge clock) begin
    if (sys_rst | ~converting) begin
      dec_cnt_ff <= 14'h0;
      chop_cnt_ff <= 9'h0;
    end else if (mod_tick) begin
      if (chop_cnt_ff != 9'h0) begin
        chop_cnt_ff <= chop_cnt_ff - 9'h1;
      end else if (word_done) begin
        dec_cnt_ff <= 14'h0;
        // after each chopped word the inputs swap and settle again
        chop_cnt_ff <= cfg.global_chop_enable ? chop_len : 9'h0; // RULE_04
      end else begin
        dec_cnt_ff <= dec_cnt_ff + 14'h1;
      end
    end
  end

  // single-shot arming; a new start wins over the completion clear
  always_ff @(posedge clock) begin
    if (sys_rst | ~run) begin
      single_armed_ff <= 1'b0;
    end else if (start_single) begin
      single_armed_ff <= 1'b1;
    end else if (word_done & single) begin
      single_armed_ff <= 1'b0;
    end
  end

  // result, wrapping counter and ready pulse
  always_ff @(posedge clock) begin
    if (sys_rst | ~run) begin
      result_ff <= 24'h0; // RULE_06
      count_ff <= 2'h0; // RULE_06
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= word_done;
      if (word_done) begin
        result_ff <= scaled;
        count_ff <= count_ff + 2'h1;
      end
    end
  end

  assign conversion_result = result_ff;
  assign conversion_counter = count_ff;
  assign data_ready = ready_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_disable_clears: assert property (@(posedge clock) disable iff (sys_rst)
    !run |=> (conversion_result == 24'h0 && conversion_counter == 2'h0)) // RULE_06
    else $error("result not cleared while disabled");
  a_word_counts: assert property (@(posedge clock) disable iff (sys_rst)
    word_done |=> (conversion_counter == $past(conversion_counter) + 2'h1)) // RULE_03
    else $error("counter did not advance on word");
  a_ready_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    data_ready |=> !data_ready ##0 $past(word_done, 2)) // RULE_03
    else $error("ready not a single pulse after word");
  a_gain_scale: assert property (@(posedge clock) disable iff (sys_rst)
    (word_done && cfg.gain_select == 2'h3) |=> conversion_result[1:0] == 2'h0) // RULE_08
    else $error("x32 result not scaled by four");
  a_chop_wait: assert property (@(posedge clock) disable iff (sys_rst)
    (word_done && mod_tick && cfg.global_chop_enable && converting) |=> chop_cnt_ff == chop_len) // RULE_05
    else $error("chop wait not loaded");

endmodule : sac_conv_core
`default_nettype wire

// ---- src/sac_pkg.sv ----
package sac_pkg;

  // register addresses (8-bit register map index)
  localparam logic [7:0] ADDR_CONV_CONFIG = 8'h82;
  localparam logic [7:0] ADDR_GAIN_CONFIG = 8'h83;
  localparam logic [7:0] ADDR_OCAL_UPPER = 8'h84;
  localparam logic [7:0] ADDR_OCAL_LOWER = 8'h85;

  // reset values
  localparam logic [15:0] RST_CONV_CONFIG = 16'h0400;
  localparam logic [15:0] RST_GAIN_CONFIG = 16'h8010;
  localparam logic [15:0] RST_OCAL_UPPER = 16'h0000;
  localparam logic [15:0] RST_OCAL_LOWER = 16'h0000;

  // writable bit masks; everything else is reserved and reads zero
  localparam logic [15:0] MASK_CONV_CONFIG = 16'h0f0f;
  localparam logic [15:0] MASK_GAIN_CONFIG = 16'h8f3f;
  localparam logic [15:0] MASK_OCAL_UPPER = 16'hffff;
  localparam logic [15:0] MASK_OCAL_LOWER = 16'hff00;

  // field positions, conversion config
  localparam int POS_CONV_MODE = 11;
  localparam int POS_OSR = 8;
  localparam int POS_GC_EN = 3;
  localparam int POS_GC_DELAY = 0;
  // field positions, input and gain config, then the lower calibration byte
  localparam int POS_CH_EN = 15;
  localparam int POS_GAIN = 10;
  localparam int POS_MUX = 8;
  localparam int POS_SRC_STEER = 5;
  localparam int POS_SINK_STEER = 4;
  localparam int POS_SRC_LEVEL = 2;
  localparam int POS_SINK_LEVEL = 0;
  localparam int POS_OCAL_LOW = 8;

  // timing bases: smallest ratio and smallest chop delay, as shift exponents
  localparam int OSR_BASE_LOG2 = 6;
  localparam int GC_DELAY_BASE_LOG2 = 1;
  // analog gain code used when the gain is 16 or 32
  localparam logic [1:0] GAIN_CODE_X8 = 2'h1;

  // conversion modes
  typedef enum logic [0:0] {
    CONV_CONTINUOUS = 1'h0,
    CONV_SINGLE_SHOT = 1'h1
  } sac_conv_mode_type;

  // input multiplexer selections
  typedef enum logic [1:0] {
    MUX_NORMAL = 2'h0,
    MUX_SWAPPED = 2'h1,
    MUX_SHORT = 2'h2,
    MUX_TEST_DAC = 2'h3
  } sac_mux_type;

endpackage : sac_pkg
